// ### shared/evp_defines.svh
/*
  Constants of the exception vector decoder: register indices, field
  positions, reset values and fixed vector offsets.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef EVP_DEFINES_SVH
`define EVP_DEFINES_SVH
`define EVP_IDX_BASE 6'h1F
`define EVP_IDX_STATUS 6'h20
`define EVP_BASE_RESET 8'hFF
`define EVP_VEC_POR 16'hFFFE
`define EVP_VEC_CLKMON 16'hFFFC
`define EVP_VEC_WDOG 16'hFFFA
`define EVP_OFS_TRAP 8'hF8
`define EVP_OFS_SOFTWARE 8'hF6
`define EVP_OFS_HIGH_PRIO 8'hF4
`define EVP_OFS_ITOP 8'hF2
`define EVP_OFS_ILOW 8'h82
`define EVP_OFS_SPUR 8'h80
`define EVP_LOW_ZERO 8'h00
`define EVP_NUM_I 57
`define EVP_ST_IPEND 16
`endif

// ### shared/evp_pkg.sv
/*
  Types of the exception vector decoder.
  Assumes evp_defines.svh is on the include path.
*/
`include "evp_defines.svh"
package evp_pkg;
   typedef struct packed {
      logic [2:0] rstReq;
      logic trapReq;
      logic softwareExceptionReq;
      logic highPriorityMaskReq;
      logic [`EVP_NUM_I-1:0] irqReq;
   } evp_req_t;
   typedef struct packed {
      logic iMask;
      logic xMask;
      logic debugActive;
      logic vecReq;
      logic stopMode;
   } evp_cpu_t;
   typedef struct packed {
      logic [15:0] vecAddr;
      logic [7:0] baseByte;
      logic [15:0] lastVec;
      logic prevReq;
      logic wake;
      logic [31:0] rdData;
   } evp_state_t;
   typedef struct packed {
      logic waitReq;
   } evp_bus_state_t;
endpackage

// ### logic/evp_prio.sv
/*
  Priority encoder over the enabled I-maskable request lines.
  Assumes same-clock request and enable inputs; purely combinational.
*/
`timescale 1ns/1ps
`include "evp_defines.svh"
module evp_prio
   import evp_pkg::*;
(
   input wire logic [`EVP_NUM_I-1:0] irqReq,
   input wire logic [`EVP_NUM_I-1:0] irqEnable,
   output logic found,
   output logic [5:0] index
);
   logic [`EVP_NUM_I-1:0] live;
   always_comb begin
      live = irqReq & irqEnable;
      found = 1'b0;
      index = 6'h00;
      for (int i = 0; i < `EVP_NUM_I; i++) begin
         if (live[i]) begin
            found = 1'b1;
            index = 6'(i);
         end
      end
   end
endmodule

// ### logic/evp_bus_slave.sv
/*
  Avalon-MM handshake: one wait cycle, then completion.
  Assumes a master that holds its request until waitrequest is low.
*/
`timescale 1ns/1ps
module evp_bus_slave
   import evp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic avRead,
   input wire logic avWrite,
   output logic avWaitRequest,
   output logic wrStrobe,
   output logic rdCapture
);
   evp_bus_state_t st_reg;
   evp_bus_state_t st_next;
   always_comb begin
      st_next = st_reg;
      st_next.waitReq = !((avRead || avWrite) && st_reg.waitReq);
   end
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_reg <= '{waitReq: 1'b1};
      end else begin
         st_reg <= st_next;
      end
   end
   assign avWaitRequest = st_reg.waitReq;
   assign wrStrobe = avWrite && !st_reg.waitReq;
   assign rdCapture = avRead && st_reg.waitReq;
   a_bus_answer: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (avRead || avWrite) && st_reg.waitReq |=> !avWaitRequest)
      else $error("bus request not answered after one wait cycle");
endmodule

// ### logic/evp_top.sv
/*
  Exception vector decoder: collects reset, trap, software, X and
  I-maskable requests and gives the CPU the winning vector address.
  Assumes requests, masks and the vector strobe come from same-clock
  logic, and an Avalon-MM master with word addressing.
*/
`timescale 1ns/1ps
`include "evp_defines.svh"
module evp_top
   import evp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [5:0] avAddress,
   input wire logic avRead,
   input wire logic avWrite,
   input wire logic [31:0] avWriteData,
   input wire logic [3:0] avByteEnable,
   output logic [31:0] avReadData,
   output logic avWaitRequest,
   input wire evp_req_t req,
   input wire logic [`EVP_NUM_I-1:0] irqEnable,
   input wire evp_cpu_t cpu,
   output logic [15:0] vectorAddr,
   output logic wakeUp
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   evp_state_t st_reg;
   evp_state_t st_next;
   logic iFound;
   logic [5:0] iIndex;
   logic wrStrobe;
   logic rdCapture;
   logic nonIPending;
   logic iQualified;
   logic [15:0] winner;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // base byte above the given low byte
   function automatic logic [15:0] withBase(
      input logic [7:0] upper,
      input logic [7:0] low
   );
      withBase = {upper, low};
   endfunction

   function automatic logic [7:0] irqLow(input logic [5:0] idx);
      logic [7:0] twice;
      twice = {1'b0, idx, 1'b0};
      irqLow = `EVP_OFS_ILOW + twice;
   endfunction

   // ---------------------------------------------------------------
   // Submodules
   // ---------------------------------------------------------------
   evp_prio u_prio (
      .irqReq(req.irqReq),
      .irqEnable(irqEnable),
      .found(iFound),
      .index(iIndex)
   );

   evp_bus_slave u_bus (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .avRead(avRead),
      .avWrite(avWrite),
      .avWaitRequest(avWaitRequest),
      .wrStrobe(wrStrobe),
      .rdCapture(rdCapture)
   );

   // ---------------------------------------------------------------
   // Priority decoder
   // ---------------------------------------------------------------
   // The source behind the X and F2 lines is chosen when the chip is
   // built; this block only sees one request line for each.
   always_comb begin
      logic [7:0] upper;
      upper = st_reg.baseByte;
      if (cpu.debugActive) begin
         upper = `EVP_BASE_RESET;
      end
      nonIPending = req.trapReq || req.softwareExceptionReq || req.highPriorityMaskReq;
      iQualified = iFound && !cpu.iMask && !nonIPending;
      if (req.rstReq[0]) begin
         winner = `EVP_VEC_POR;
      end else if (req.rstReq[1]) begin
         winner = `EVP_VEC_CLKMON;
      end else if (req.rstReq[2]) begin
         winner = `EVP_VEC_WDOG;
      end else if (req.trapReq) begin
         winner = withBase(upper, `EVP_OFS_TRAP);
      end else if (req.softwareExceptionReq) begin
         winner = withBase(upper, `EVP_OFS_SOFTWARE);
      // X gated by X mask only
      end else if (req.highPriorityMaskReq && !cpu.xMask) begin
         winner = withBase(upper, `EVP_OFS_HIGH_PRIO);
      end else if (iQualified) begin
         winner = withBase(upper, irqLow(iIndex));
      end else begin
         winner = withBase(upper, `EVP_OFS_SPUR);
      end
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.prevReq = cpu.vecReq;
      if (!cpu.vecReq) begin
         st_next.vecAddr = winner;
      end
      if (cpu.vecReq && !st_reg.prevReq) begin
         st_next.lastVec = st_reg.vecAddr;
      end
      st_next.wake = cpu.stopMode &&
         ((iFound && !cpu.iMask) || req.highPriorityMaskReq);
      if (wrStrobe && avAddress == `EVP_IDX_BASE && avByteEnable[0]) begin
         st_next.baseByte = avWriteData[7:0];
      end
      if (req.rstReq != 3'h0) begin
         st_next.baseByte = `EVP_BASE_RESET;
      end
      if (rdCapture) begin
         st_next.rdData = 32'h0000_0000;
         if (avAddress == `EVP_IDX_BASE) begin
            st_next.rdData[7:0] = st_reg.baseByte;
         end else if (avAddress == `EVP_IDX_STATUS) begin
            st_next.rdData[15:0] = st_reg.lastVec;
            st_next.rdData[`EVP_ST_IPEND] = iQualified;
         end
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   // Wake is registered, so it needs a running clock; a fully
   // clockless stop wake would have to be built from the raw lines
   // outside this block.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_reg.vecAddr <= `EVP_VEC_POR;
         st_reg.baseByte <= `EVP_BASE_RESET;
         st_reg.lastVec <= 16'h0000;
         st_reg.prevReq <= 1'b0;
         st_reg.wake <= 1'b0;
         st_reg.rdData <= 32'h0000_0000;
      end else begin
         st_reg <= st_next;
      end
   end

   assign vectorAddr = st_reg.vecAddr;
   assign wakeUp = st_reg.wake;
   assign avReadData = st_reg.rdData;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_base_reset: assert property (
      @(posedge sys_clk)
      $fell(sys_rst) |-> st_reg.baseByte == `EVP_BASE_RESET)
      else $error("base byte not all ones after reset");

   a_reset_relocate: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      req.rstReq != 3'h0 |=> st_reg.baseByte == `EVP_BASE_RESET)
      else $error("reset request did not restore base byte");

   a_reset_vector: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      !cpu.vecReq && req.rstReq[0] |=> vectorAddr == `EVP_VEC_POR)
      else $error("power-on reset vector not given");

   a_watchdog_rank: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      !cpu.vecReq && req.rstReq == 3'h4 |=> vectorAddr == `EVP_VEC_WDOG)
      else $error("watchdog reset vector not given");

   a_debug_upper: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      !cpu.vecReq && cpu.debugActive
      |=> vectorAddr[15:8] == `EVP_BASE_RESET)
      else $error("debug state did not force upper byte");

   a_base_upper: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      !cpu.vecReq && !cpu.debugActive && req.rstReq == 3'h0
      |=> vectorAddr[15:8] == $past(st_reg.baseByte))
      else $error("upper vector byte differs from base byte");

   a_trap_wins: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      !cpu.vecReq && req.rstReq == 3'h0 && req.trapReq
      |=> vectorAddr[7:0] == `EVP_OFS_TRAP)
      else $error("trap did not win below resets");

   a_x_preempt: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      !cpu.vecReq && req.rstReq == 3'h0 && !req.trapReq && !req.softwareExceptionReq
      && req.highPriorityMaskReq && !cpu.xMask
      |=> vectorAddr[7:0] == `EVP_OFS_HIGH_PRIO)
      else $error("unmasked X request not granted");

   a_imask_block: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      !cpu.vecReq && req.rstReq == 3'h0 && cpu.iMask
      |=> vectorAddr[7:0] == `EVP_OFS_SPUR
      || vectorAddr[7:0] >= `EVP_OFS_HIGH_PRIO)
      else $error("I-maskable vector given with I mask set");

   a_spurious: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      !cpu.vecReq && req.rstReq == 3'h0 && !nonIPending
      && (req.irqReq & irqEnable) == '0
      |=> vectorAddr[7:0] == `EVP_OFS_SPUR)
      else $error("spurious vector not given when idle");

   a_vector_hold: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      cpu.vecReq |=> $stable(vectorAddr))
      else $error("vector changed while strobe high");

   a_stop_wake: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      cpu.stopMode && req.highPriorityMaskReq |=> wakeUp)
      else $error("X request in stop did not wake");

   // ---------------------------------------------------------------
   // Checks on ranking, register and wake paths
   // ---------------------------------------------------------------
   a_clkmon_vector: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      !cpu.vecReq && req.rstReq[1] && !req.rstReq[0] |=> vectorAddr == `EVP_VEC_CLKMON)
      else $error("clock monitor reset vector not given");

   a_fixed_reset: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      !cpu.vecReq && req.rstReq != 3'h0 |=> vectorAddr[15:8] == `EVP_BASE_RESET)
      else $error("reset vector moved with the base byte");

   a_soft_wins: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      !cpu.vecReq && req.rstReq == 3'h0 && !req.trapReq && req.softwareExceptionReq
      |=> vectorAddr[7:0] == `EVP_OFS_SOFTWARE)
      else $error("software exception did not win below trap");

   a_nest_unmasked: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      !cpu.vecReq && req.rstReq == 3'h0 && !req.trapReq && req.softwareExceptionReq
      && cpu.iMask
      |=> vectorAddr[7:0] == `EVP_OFS_SOFTWARE)
      else $error("software exception blocked by the I mask");

   a_i_rank_last: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      !cpu.vecReq && req.rstReq == 3'h0
      && (req.trapReq || req.softwareExceptionReq || (req.highPriorityMaskReq && !cpu.xMask))
      |=> vectorAddr[7:0] >= `EVP_OFS_HIGH_PRIO)
      else $error("I-maskable vector outranked a higher request");

   a_i_qualified: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      !cpu.vecReq && req.rstReq == 3'h0 && !cpu.iMask && (req.irqReq & irqEnable) != '0
      && !req.trapReq && !req.softwareExceptionReq && !req.highPriorityMaskReq
      |=> vectorAddr[7:0] >= `EVP_OFS_ILOW && vectorAddr[7:0] <= `EVP_OFS_ITOP)
      else $error("qualified I-maskable request not granted");

   a_i_top_line: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      !cpu.vecReq && req.rstReq == 3'h0 && !cpu.iMask
      && req.irqReq[`EVP_NUM_I-1] && irqEnable[`EVP_NUM_I-1]
      && !req.trapReq && !req.softwareExceptionReq && !req.highPriorityMaskReq
      |=> vectorAddr[7:0] == `EVP_OFS_ITOP)
      else $error("top I-maskable line not ranked first");

   a_x_masked: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      !cpu.vecReq && req.rstReq == 3'h0 && !req.trapReq && !req.softwareExceptionReq
      && req.highPriorityMaskReq && cpu.xMask
      |=> vectorAddr[7:0] == `EVP_OFS_SPUR)
      else $error("masked X request let an I-maskable vector through");

   a_spur_base: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      !cpu.vecReq && !cpu.debugActive && req.rstReq == 3'h0 && (req.irqReq & irqEnable) == '0
      && !req.trapReq && !req.softwareExceptionReq && !req.highPriorityMaskReq
      |=> vectorAddr == ({$past(st_reg.baseByte), `EVP_LOW_ZERO} | {8'h00, `EVP_OFS_SPUR}))
      else $error("spurious vector not at base plus its offset");

   a_base_write: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      wrStrobe && avAddress == `EVP_IDX_BASE && avByteEnable[0] && req.rstReq == 3'h0
      |=> st_reg.baseByte == $past(avWriteData[7:0]))
      else $error("base byte write did not land");

   a_base_keep: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      !(wrStrobe && avAddress == `EVP_IDX_BASE && avByteEnable[0]) && req.rstReq == 3'h0
      |=> $stable(st_reg.baseByte))
      else $error("base byte changed without a write");

   a_read_base: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      rdCapture && avAddress == `EVP_IDX_BASE
      |=> avReadData == {24'h00_0000, $past(st_reg.baseByte)})
      else $error("base byte read back wrong");

   a_last_vector: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      cpu.vecReq && !st_reg.prevReq |=> st_reg.lastVec == $past(vectorAddr))
      else $error("vector at strobe rise not recorded");

   a_read_status: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      rdCapture && avAddress == `EVP_IDX_STATUS
      |=> avReadData[15:0] == $past(st_reg.lastVec))
      else $error("recorded vector read back wrong");

   a_wake_masked: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      cpu.stopMode && cpu.iMask && !req.highPriorityMaskReq |=> !wakeUp)
      else $error("masked I request woke the system");

   a_wake_run: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      !cpu.stopMode |=> !wakeUp)
      else $error("wake raised outside stop");
endmodule

// ### verification/evp_cpu_model.sv
/*
  Behavioural model of the CPU core that fetches exception vectors.
  Assumes the decoder's vector output and the shared system clock.
*/
`timescale 1ns/1ps
module evp_cpu_model
   import evp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic [15:0] vectorAddr,
   output evp_cpu_t cpu
);
   // ----------------------------------------
   // Mask state out of reset
   // ----------------------------------------
   // masks set initially
   initial begin
      cpu = '{iMask: 1'b1, xMask: 1'b1, default: 1'b0};
   end

   task automatic set_mode(input logic im, input logic xm, input logic dbg, input logic stp);
      @(posedge sys_clk);
      cpu.iMask <= im;
      cpu.xMask <= xm;
      cpu.debugActive <= dbg;
      cpu.stopMode <= stp;
   endtask

   // The vector is taken one edge into the strobe; a second look proves it was held.
   task automatic fetch(output logic [15:0] vec, output logic held);
      @(posedge sys_clk);
      cpu.vecReq <= 1'b1;
      @(posedge sys_clk);
      vec = vectorAddr;
      @(posedge sys_clk);
      held = (vectorAddr === vec);
      cpu.vecReq <= 1'b0;
   endtask
endmodule

// ### verification/tb.sv
/*
  Self-checking bench of the exception vector decoder.
  Assumes evp_pkg, the design files and the CPU model are compiled first.
*/
`timescale 1ns/1ps
`include "evp_defines.svh"
module tb
   import evp_pkg::*;
;
   logic sys_clk;
   logic sys_rst;
   logic [5:0] avAddress;
   logic avRead;
   logic avWrite;
   logic [31:0] avWriteData;
   logic [3:0] avByteEnable;
   logic [31:0] avReadData;
   logic avWaitRequest;
   evp_req_t req;
   logic [`EVP_NUM_I-1:0] irqEnable;
   wire evp_cpu_t cpu;
   logic [15:0] vectorAddr;
   logic wakeUp;
   int nMismatch = 0;
   int totalChecks = 0;
   int cycles = 0;
   logic [31:0] q;
   localparam logic [56:0] ALL = {57{1'b1}};
   localparam logic [56:0] TOP = 57'h1 << 56;

   evp_top DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .avAddress(avAddress), .avRead(avRead),
      .avWrite(avWrite), .avWriteData(avWriteData), .avByteEnable(avByteEnable),
      .avReadData(avReadData), .avWaitRequest(avWaitRequest), .req(req),
      .irqEnable(irqEnable), .cpu(cpu), .vectorAddr(vectorAddr), .wakeUp(wakeUp));
   evp_cpu_model u_cpu (.sys_clk(sys_clk), .vectorAddr(vectorAddr), .cpu(cpu));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic wrapUp;
      $display("checks %0d mismatches %0d", totalChecks, nMismatch);
      if (nMismatch == 0 && totalChecks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         nMismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] rd);
      @(posedge sys_clk);
      avAddress <= a;
      avWriteData <= d;
      avByteEnable <= be;
      avWrite <= wr;
      avRead <= !wr;
      do begin
         @(posedge sys_clk);
      end while (avWaitRequest !== 1'b0);
      rd = avReadData;
      avWrite <= 1'b0;
      avRead <= 1'b0;
   endtask

   task automatic vec(input logic [5:0] top, input logic [56:0] irq, input logic [56:0] en,
                      input logic im, input logic dbg, input logic [15:0] exp);
      logic [15:0] v;
      logic h;
      @(posedge sys_clk);
      req <= {top, irq};
      irqEnable <= en;
      u_cpu.set_mode(im, 1'b0, dbg, 1'b0);
      u_cpu.fetch(v, h);
      check({16'h0000, v}, {16'h0000, exp});
      check({31'h0, h}, 32'h1);
   endtask

   task automatic wake(input logic [5:0] top, input logic [56:0] en, input logic im,
                       input logic exp);
      @(posedge sys_clk);
      req <= {top, 57'h1};
      irqEnable <= en;
      u_cpu.set_mode(im, 1'b1, 1'b0, 1'b1);
      repeat (2) @(posedge sys_clk);
      check({31'h0, wakeUp}, {31'h0, exp});
   endtask

   // ----------------------------------------
   // Clock, reset and timeout
   // ----------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         nMismatch++;
         wrapUp();
      end
   end

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      sys_rst = 1'b1;
      avAddress = 6'h00;
      avRead = 1'b0;
      avWrite = 1'b0;
      avWriteData = 32'h0;
      avByteEnable = 4'h0;
      req = '0;
      irqEnable = '0;
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'b0;
      bus(1'b0, 6'h1F, 32'h0, 4'hF, q);
      check(q, 32'h000000FF);
      bus(1'b0, 6'h3F, 32'h0, 4'hF, q);
      check(q, 32'h0);
      bus(1'b1, 6'h1F, 32'h12, 4'h1, q);
      bus(1'b1, 6'h1F, 32'h34, 4'h0, q);
      bus(1'b0, 6'h1F, 32'h0, 4'hF, q);
      check(q, 32'h00000012);
      vec(6'b000111, ALL, ALL, 1'b0, 1'b0, 16'h12F8);
      vec(6'b000011, ALL, ALL, 1'b0, 1'b0, 16'h12F6);
      vec(6'b000001, ALL, ALL, 1'b0, 1'b0, 16'h12F4);
      vec(6'b000001, ALL, ALL, 1'b1, 1'b0, 16'h12F4);
      vec(6'b000010, 57'h0, 57'h0, 1'b1, 1'b0, 16'h12F6);
      vec(6'b000000, TOP | 57'h1, ALL, 1'b0, 1'b0, 16'h12F2);
      vec(6'b000000, 57'h21, ALL, 1'b0, 1'b0, 16'h128C);
      bus(1'b0, 6'h20, 32'h0, 4'hF, q);
      check(q, 32'h0001128C);
      vec(6'b000000, 57'h21, 57'h1, 1'b0, 1'b0, 16'h1282);
      vec(6'b000000, 57'h21, ALL, 1'b1, 1'b0, 16'h1280);
      vec(6'b000000, 57'h0, ALL, 1'b0, 1'b0, 16'h1280);
      vec(6'b000010, 57'h0, 57'h0, 1'b0, 1'b1, 16'hFFF6);
      vec(6'b000000, 57'h0, 57'h0, 1'b0, 1'b1, 16'hFF80);
      wake(6'b000000, 57'h1, 1'b0, 1'b1);
      wake(6'b000000, 57'h1, 1'b1, 1'b0);
      wake(6'b000001, 57'h0, 1'b1, 1'b1);
      vec(6'b100000, ALL, ALL, 1'b0, 1'b0, 16'hFFFA);
      vec(6'b110111, ALL, ALL, 1'b0, 1'b0, 16'hFFFC);
      vec(6'b111111, ALL, ALL, 1'b0, 1'b0, 16'hFFFE);
      bus(1'b0, 6'h1F, 32'h0, 4'hF, q);
      check(q, 32'h000000FF);
      wrapUp();
   end
endmodule
